// ==== src/rtc_pkg.sv ====
// Package of the indirect real time clock register interface.
// Assumes one system clock; the counter tick arrives as a level input.
package rtc_pkg;

	// ------------------------------------------------------------------
	// Host side register selects
	// ------------------------------------------------------------------
	localparam logic [1:0] SEL_LOCK_KEY = 2'h0;
	localparam logic [1:0] SEL_ADDRESS  = 2'h1;
	localparam logic [1:0] SEL_DATA     = 2'h2;

	localparam logic [7:0] LOCK_KEY_UNLOCKED = 8'h02;

	// ------------------------------------------------------------------
	// Address register fields
	// ------------------------------------------------------------------
	localparam int          AUTO_READ_BIT = 6;
	localparam logic [7:0]  ADDRESS_WRITE_MASK = 8'h5F;
	localparam logic [7:0]  ADDRESS_RESET = 8'h00;

	// ------------------------------------------------------------------
	// Internal register offsets
	// ------------------------------------------------------------------
	localparam logic [4:0] ADDR_CAPTURE0     = 5'h00;
	localparam logic [4:0] ADDR_CAPTURE3     = 5'h03;
	localparam logic [4:0] ADDR_STATE_CTRL   = 5'h04;
	localparam logic [4:0] ADDR_OSC_CTRL     = 5'h05;
	localparam logic [4:0] ADDR_OSC_LOAD     = 5'h06;
	localparam logic [4:0] ADDR_ALARM_CFG    = 5'h07;
	localparam logic [4:0] ADDR_ALARM0_B0    = 5'h08;
	localparam logic [4:0] ADDR_ALARM1_B0    = 5'h0C;
	localparam logic [4:0] ADDR_ALARM2_B0    = 5'h10;
	localparam logic [4:0] ADDR_ALARM2_B3    = 5'h13;

	// ------------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------------
	localparam int         RUN_BIT        = 7;
	localparam int         SET_BIT        = 1;
	localparam int         CAPTURE_BIT    = 0;
	localparam int         MISSING_EN_BIT = 6;
	localparam int         MISSING_FLAG_BIT = 2;
	localparam int         ALARM_RESET_SEL_BIT = 5;
	localparam int         MISSING_RESET_SEL_BIT = 4;
	localparam logic [7:0] STATE_CTRL_RESET = 8'h00;
	localparam logic [7:0] OSC_CTRL_RESET   = 8'h00;
	localparam logic [7:0] OSC_LOAD_RESET   = 8'h00;
	localparam logic [7:0] ALARM_CFG_RESET  = 8'h00;
	localparam int         LOAD_LEVEL_LSB   = 0;
	localparam int         LOAD_AUTO_STEP_BIT = 7;
	localparam int         ALARM_EN_LSB     = 0;
	localparam int         ALARM_FLAG_LSB   = 4;

	// Missing clock: no tick within this many system cycles
	localparam logic [11:0] MISSING_LIMIT = 12'hFFF;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [1:0] sel;
		logic [7:0] wdata;
	} host_req_t;

	typedef struct packed {
		logic alarm_wake;
		logic alarm_reset;
		logic missing_wake;
		logic missing_reset;
	} event_out_t;

endpackage

// ==== src/rtc_indirect_if.sv ====
// Indirect register path and register map of a 32-bit real time clock.
// Assumes host strobes and the timebase tick level are synchronous.
//
// Contract
// - Exactly three host registers: lock key, indirect address, indirect data.
// - Internal registers reachable only through address and data registers.
// - Addresses 0x00-0x03 are capture bytes setting or reading the timer.
// - Address 0x04 is the clock state control register.
// - Address 0x05 is the oscillator control register.
// - Address 0x06 holds load capacitance level and auto-stepping enable.
// - Address 0x07 holds enable and flag for each of three alarms.
// - Three 32-bit alarms, four bytes each, at 0x08, 0x0C, 0x10.
// - Lock key ignores writes; interface always unlocked.
// - Address register selects target of following data accesses.
// - Data register write writes that byte into selected register.
// - Host writes address then reads data; device returns register copy.
// - With auto-read, each data read starts next indirect read.
// - Auto-read enabled by address register bit 6.
// - Address increments after each capture or alarm byte access.
// - Time kept by a 32-bit counter.
// - Alarm and missing-clock events, each selectable reset or wake.
// - Load capacitance has 16 levels.
// - Address field bits 4:0; bits 7 and 5 read zero.
// - Lock key reads 0x02.
`timescale 1ns/1ns
module rtc_indirect_if (
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire rtc_pkg::host_req_t  host_req,
	output logic [7:0]               host_rdata,
	input  wire logic                timebase_tick,
	output rtc_pkg::event_out_t      events,
	output logic [3:0]               load_cap_level,
	output logic                     load_cap_auto_stepping,
	output logic [7:0]               oscillator_control
);
	import rtc_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [7:0]  indirect_address_reg;
	logic [7:0]  indirect_data_reg;
	logic [31:0] counter;
	logic [31:0] capture;
	logic [31:0] alarm_value [3];
	logic [7:0]  clock_state_control;
	logic [7:0]  oscillator_load_config;
	logic [7:0]  alarm_enable_flags;
	logic        tick_q;
	logic        tick_edge;
	logic [11:0] missing_count;
	logic        missing_event;
	logic [2:0]  alarm_hit;
	logic        data_wr;
	logic        data_rd;
	logic        auto_read_enable;
	logic [4:0]  addr;
	logic [7:0]  selected_byte;
	logic        addr_wr;
	logic        ctrl_wr;
	logic [4:0]  read_addr;

	// Byte within a 32-bit word
	function automatic logic [7:0] byte_of(input logic [31:0] w,
		input logic [1:0] idx);
		byte_of = w[{idx, 3'h0} +: 8];
	endfunction

	// Capture bytes
	function automatic logic is_capture(input logic [4:0] a);
		is_capture = a <= ADDR_CAPTURE3;
	endfunction

	// Alarm value bytes
	function automatic logic is_alarm(input logic [4:0] a);
		is_alarm = a >= ADDR_ALARM0_B0 && a <= ADDR_ALARM2_B3;
	endfunction

	// Alarm word of an alarm byte
	function automatic logic [1:0] alarm_index(input logic [4:0] a);
		logic [4:0] offset;
		offset = a - ADDR_ALARM0_B0;
		alarm_index = offset[3:2];
	endfunction

	// Lowest bit of a byte lane
	function automatic logic [4:0] lane_lsb(input logic [4:0] a);
		lane_lsb = {a[1:0], 3'h0};
	endfunction

	// Capture or alarm bytes auto-increment
	function automatic logic is_multibyte(input logic [4:0] a);
		is_multibyte = is_capture(a) || is_alarm(a);
	endfunction

	// ------------------------------------------------------------------
	// Host decode
	// ------------------------------------------------------------------
	assign addr = indirect_address_reg[4:0];
	assign auto_read_enable = indirect_address_reg[AUTO_READ_BIT];
	assign addr_wr = host_req.wr && host_req.sel == SEL_ADDRESS;
	assign data_wr = host_req.wr && host_req.sel == SEL_DATA;
	assign data_rd = host_req.rd && host_req.sel == SEL_DATA;
	assign ctrl_wr = data_wr && addr == ADDR_STATE_CTRL;
	assign tick_edge = timebase_tick && !tick_q;

	// ------------------------------------------------------------------
	// Internal register read mux
	// ------------------------------------------------------------------
	// New address on an address write, else the byte the address
	// advances to, so an auto-read preloads fresh contents
	always_comb begin
		if (addr_wr) begin
			read_addr = host_req.wdata[4:0];
		end else if (is_multibyte(addr)) begin
			read_addr = addr + 5'h01;
		end else begin
			read_addr = addr;
		end
	end

	always_comb begin
		case (read_addr) inside
			[ADDR_CAPTURE0:ADDR_CAPTURE3]:
				selected_byte = byte_of(capture, read_addr[1:0]);
			ADDR_STATE_CTRL:
				selected_byte = clock_state_control;
			ADDR_OSC_CTRL:
				selected_byte = oscillator_control;
			ADDR_OSC_LOAD:
				selected_byte = oscillator_load_config;
			ADDR_ALARM_CFG:
				selected_byte = alarm_enable_flags;
			[ADDR_ALARM0_B0:ADDR_ALARM2_B3]:
				selected_byte = byte_of(alarm_value[alarm_index(read_addr)],
					read_addr[1:0]);
			default:
				selected_byte = 8'h00;
		endcase
	end

	// ------------------------------------------------------------------
	// Host registers
	// ------------------------------------------------------------------
	always_comb begin
		case (host_req.sel)
			SEL_LOCK_KEY: host_rdata = LOCK_KEY_UNLOCKED;
			SEL_ADDRESS:  host_rdata = indirect_address_reg;
			SEL_DATA:     host_rdata = indirect_data_reg;
			default:      host_rdata = 8'h00;
		endcase
	end

	// Address register and auto-increment
	always_ff @(posedge core_clk) begin
		if (rst) begin
			indirect_address_reg <= ADDRESS_RESET;
		end else if (addr_wr) begin
			indirect_address_reg <= host_req.wdata & ADDRESS_WRITE_MASK;
		end else if ((data_wr || data_rd) && is_multibyte(addr)) begin
			indirect_address_reg[4:0] <= addr + 5'h01;
		end
	end

	// Data register: loaded by an address write, a data write or an auto-read
	always_ff @(posedge core_clk) begin
		if (rst) begin
			indirect_data_reg <= 8'h00;
		end else if (addr_wr) begin
			indirect_data_reg <= selected_byte;
		end else if (data_wr) begin
			indirect_data_reg <= host_req.wdata;
		end else if (data_rd && auto_read_enable) begin
			indirect_data_reg <= selected_byte;
		end
	end

	// ------------------------------------------------------------------
	// Counter and capture
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= timebase_tick;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			counter <= 32'h0000_0000;
		end else if (ctrl_wr && host_req.wdata[SET_BIT]) begin
			counter <= capture;
		end else if (tick_edge && clock_state_control[RUN_BIT]) begin
			counter <= counter + 32'h0000_0001;
		end
	end

	// Capture snapshot taken in one cycle keeps all bytes coherent
	always_ff @(posedge core_clk) begin
		if (rst) begin
			capture <= 32'h0000_0000;
		end else if (data_wr && is_capture(addr)) begin
			capture[lane_lsb(addr) +: 8] <= host_req.wdata;
		end else if (ctrl_wr && host_req.wdata[CAPTURE_BIT]) begin
			capture <= counter;
		end
	end

	// ------------------------------------------------------------------
	// Control and oscillator registers
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			clock_state_control <= STATE_CTRL_RESET;
		end else begin
			if (ctrl_wr) begin
				clock_state_control <= host_req.wdata
					& ~(8'h01 << SET_BIT) & ~(8'h01 << CAPTURE_BIT);
			end
			// Missing flag set wins over a same-cycle write
			if (missing_event) begin
				clock_state_control[MISSING_FLAG_BIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			oscillator_control <= OSC_CTRL_RESET;
		end else if (data_wr && addr == ADDR_OSC_CTRL) begin
			oscillator_control <= host_req.wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			oscillator_load_config <= OSC_LOAD_RESET;
		end else if (data_wr && addr == ADDR_OSC_LOAD) begin
			// Only level and auto-step are stored; other bits read zero
			oscillator_load_config <= host_req.wdata
				& ((8'h01 << LOAD_AUTO_STEP_BIT)
				| (8'h0F << LOAD_LEVEL_LSB));
		end
	end

	assign load_cap_level = oscillator_load_config[LOAD_LEVEL_LSB +: 4];
	assign load_cap_auto_stepping = oscillator_load_config[LOAD_AUTO_STEP_BIT];

	// ------------------------------------------------------------------
	// Alarms
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < 3; i++) begin
				alarm_value[i] <= 32'h0000_0000;
			end
		end else if (data_wr && is_alarm(addr)) begin
			alarm_value[alarm_index(addr)][lane_lsb(addr) +: 8]
				<= host_req.wdata;
		end
	end

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			alarm_hit[i] = tick_edge && alarm_enable_flags[ALARM_EN_LSB + i]
				&& counter == alarm_value[i];
		end
	end

	// Flag set wins over a software clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			alarm_enable_flags <= ALARM_CFG_RESET;
		end else begin
			if (data_wr && addr == ADDR_ALARM_CFG) begin
				alarm_enable_flags <= host_req.wdata;
			end
			for (int i = 0; i < 3; i++) begin
				if (alarm_hit[i]) begin
					alarm_enable_flags[ALARM_FLAG_LSB + i] <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Missing clock detector and event routing
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			missing_count <= 12'h000;
		end else if (tick_edge
			|| !clock_state_control[MISSING_EN_BIT]) begin
			missing_count <= 12'h000;
		end else if (missing_count != MISSING_LIMIT) begin
			missing_count <= missing_count + 12'h001;
		end
	end

	assign missing_event = clock_state_control[MISSING_EN_BIT]
		&& missing_count == MISSING_LIMIT - 12'h001;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			events <= '0;
		end else begin
			events.alarm_reset <= |alarm_hit
				&& clock_state_control[ALARM_RESET_SEL_BIT];
			events.alarm_wake <= |alarm_hit
				&& !clock_state_control[ALARM_RESET_SEL_BIT];
			events.missing_reset <= missing_event
				&& clock_state_control[MISSING_RESET_SEL_BIT];
			events.missing_wake <= missing_event
				&& !clock_state_control[MISSING_RESET_SEL_BIT];
		end
	end

endmodule

// ==== test/rtc_indirect_if_monitor.sv ====
// Checker of the indirect clock register interface.
// Assumes a bind to every port of rtc_indirect_if.
`timescale 1ns/1ns
module rtc_indirect_if_monitor
	import rtc_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       rst,
	input wire host_req_t  host_req,
	input wire logic [7:0] host_rdata,
	input wire logic       timebase_tick,
	input wire event_out_t events,
	input wire logic [3:0] load_cap_level,
	input wire logic       load_cap_auto_stepping,
	input wire logic [7:0] oscillator_control
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_key_reads_fixed: assert property (
		host_req.sel == SEL_LOCK_KEY |-> host_rdata == LOCK_KEY_UNLOCKED)
		else $error("lock key read wrong");
	a_unmapped_reads_zero: assert property (
		host_req.sel == 2'h3 |-> host_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_addr_bits_zero: assert property (
		host_req.sel == SEL_ADDRESS |-> !host_rdata[7] && !host_rdata[5])
		else $error("address spare bits set");
	a_addr_write_held: assert property (
		(host_req.wr && host_req.sel == SEL_ADDRESS) ##1
		(host_req.sel == SEL_ADDRESS && !host_req.wr) |->
		host_rdata == ($past(host_req.wdata) & ADDRESS_WRITE_MASK))
		else $error("address write not held");
	a_data_holds_idle: assert property (
		(host_req.sel == SEL_DATA && !host_req.rd && !host_req.wr) ##1
		(host_req.sel == SEL_DATA) |-> $stable(host_rdata))
		else $error("data register moved");
	a_data_write_loads: assert property (
		(host_req.wr && host_req.sel == SEL_DATA) ##1
		(host_req.sel == SEL_DATA && !host_req.wr) |->
		host_rdata == $past(host_req.wdata))
		else $error("data write not loaded");
	a_osc_ctrl_write: assert property (
		(host_req.wr && host_req.sel == SEL_ADDRESS &&
		host_req.wdata[4:0] == ADDR_OSC_CTRL) ##1
		(host_req.wr && host_req.sel == SEL_DATA) |=>
		oscillator_control == $past(host_req.wdata))
		else $error("oscillator control not written");
	a_load_cfg_write: assert property (
		(host_req.wr && host_req.sel == SEL_ADDRESS &&
		host_req.wdata[4:0] == ADDR_OSC_LOAD) ##1
		(host_req.wr && host_req.sel == SEL_DATA) |=>
		load_cap_level == $past(host_req.wdata[3:0]) &&
		load_cap_auto_stepping == $past(host_req.wdata[7]))
		else $error("load config not written");
	a_event_one_pulse: assert property (
		events != 4'h0 |=> events == 4'h0)
		else $error("event longer than one cycle");
	a_event_one_route: assert property (
		!(events.alarm_wake && events.alarm_reset) &&
		!(events.missing_wake && events.missing_reset))
		else $error("event on both routes");
endmodule
bind rtc_indirect_if rtc_indirect_if_monitor u_mon (
	.core_clk(core_clk), .rst(rst), .host_req(host_req),
	.host_rdata(host_rdata), .timebase_tick(timebase_tick),
	.events(events), .load_cap_level(load_cap_level),
	.load_cap_auto_stepping(load_cap_auto_stepping),
	.oscillator_control(oscillator_control)
);

// ==== test/rtc_host_model.sv ====
// Processor side model: one-cycle strobes on the register bus.
// Assumes the answer is combinational within the strobe cycle.
`timescale 1ns/1ns
module rtc_host_model
	import rtc_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic [7:0] host_rdata,
	output host_req_t       host_req
);
	initial host_req = '0;
	// Plain moves only, never read-modify-write
	task automatic bus_wr(input logic [1:0] s, input logic [7:0] d);
		@(posedge core_clk);
		host_req <= '{rd: 1'b0, wr: 1'b1, sel: s, wdata: d};
	endtask
	task automatic bus_rd(input logic [1:0] s, output logic [7:0] d);
		@(posedge core_clk);
		host_req <= '{rd: 1'b1, wr: 1'b0, sel: s, wdata: 8'h00};
		#1 d = host_rdata;
	endtask
	// Strobes drop; select and byte stay as last driven
	task automatic bus_idle();
		@(posedge core_clk);
		host_req.rd <= 1'b0;
		host_req.wr <= 1'b0;
	endtask
	task automatic wr32(input logic [7:0] a, input logic [31:0] v);
		bus_wr(SEL_ADDRESS, a);
		for (int i = 0; i < 4; i++) begin
			bus_wr(SEL_DATA, v[8*i +: 8]);
		end
		bus_idle();
	endtask
	task automatic rd32(input logic [7:0] a, output logic [31:0] v);
		logic [7:0] d;
		bus_wr(SEL_ADDRESS, a | 8'h40);
		for (int i = 0; i < 4; i++) begin
			bus_rd(SEL_DATA, d);
			v[8*i +: 8] = d;
		end
		bus_idle();
	endtask
endmodule

// ==== test/tb_rtc_indirect_if.sv ====
// Self-checking bench of the indirect clock register interface.
// Assumes rtc_host_model drives the bus and the checker is bound.
`timescale 1ns/1ns
module tb_rtc_indirect_if;
	import rtc_pkg::*;
	logic        core_clk;
	logic        rst;
	host_req_t   host_req;
	logic [7:0]  host_rdata;
	logic        timebase_tick;
	event_out_t  events;
	logic [3:0]  load_cap_level;
	logic        load_cap_auto_stepping;
	logic [7:0]  oscillator_control;
	int          num_errors;
	int          num_checks;
	int          n_wake;
	int          n_miss;
	int          n_reset;
	logic [31:0] v;
	logic [31:0] c;
	logic [7:0]  d;
	logic [7:0]  x [2];
	logic [7:0]  bases [3] = '{8'h08, 8'h0C, 8'h10};
	rtc_indirect_if u_dut (.core_clk(core_clk), .rst(rst),
		.host_req(host_req), .host_rdata(host_rdata),
		.timebase_tick(timebase_tick), .events(events),
		.load_cap_level(load_cap_level),
		.load_cap_auto_stepping(load_cap_auto_stepping),
		.oscillator_control(oscillator_control));
	rtc_host_model u_host (.core_clk(core_clk), .host_rdata(host_rdata),
		.host_req(host_req));
	initial core_clk = 1'b0;
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (!rst) begin
			n_wake <= n_wake + int'(events.alarm_wake === 1'b1);
			n_miss <= n_miss + int'(events.missing_wake === 1'b1);
			n_reset <= n_reset + int'(events.alarm_reset !== 1'b0)
				+ int'(events.missing_reset !== 1'b0);
		end
	end
	// Unstored load config bits read as zero
	function automatic logic [7:0] reg_mask(input logic [7:0] a);
		return (a == 8'h06) ? 8'h8F : 8'hFF;
	endfunction
	task automatic fail_line(input logic [31:0] g, input logic [31:0] e);
		num_errors++;
		$display("ERROR t=%0t got %h exp %h", $time, g, e);
	endtask
	task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) fail_line(g, e);
	endtask
	task automatic check_word(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) fail_line(g, e);
	endtask
	task automatic check_count(input int g, input int e);
		num_checks++;
		if (g != e) fail_line(g, e);
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge core_clk) timebase_tick <= 1'b1;
			repeat (3) @(posedge core_clk);
			timebase_tick <= 1'b0;
			repeat (3) @(posedge core_clk);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		complete_run();
	end
	initial begin
		void'($urandom(32'h95F37AEB));
		{num_errors, num_checks, n_wake, n_miss, n_reset} = '0;
		rst = 1'b1;
		timebase_tick = 1'b0;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		u_host.bus_rd(SEL_LOCK_KEY, d);
		check_byte(d, LOCK_KEY_UNLOCKED);
		u_host.bus_wr(SEL_LOCK_KEY, 8'($urandom));
		u_host.bus_rd(SEL_LOCK_KEY, d);
		check_byte(d, LOCK_KEY_UNLOCKED);
		u_host.bus_wr(2'h3, 8'hFF);
		u_host.bus_rd(2'h3, d);
		check_byte(d, 8'h00);
		u_host.bus_wr(SEL_ADDRESS, 8'hFF);
		u_host.bus_rd(SEL_ADDRESS, d);
		check_byte(d, 8'h5F);
		$display("test key and address done");
		foreach (bases[i]) begin
			v = $urandom;
			u_host.wr32(bases[i], v);
			u_host.bus_rd(SEL_ADDRESS, d);
			check_byte(d, bases[i] + 8'h04);
			u_host.rd32(bases[i], c);
			check_word(c, v);
		end
		u_host.bus_wr(SEL_ADDRESS, 8'h10);
		u_host.bus_rd(SEL_DATA, d);
		u_host.bus_rd(SEL_DATA, d);
		check_byte(d, v[7:0]);
		u_host.bus_rd(SEL_ADDRESS, d);
		check_byte(d, 8'h12);
		$display("test alarm values done");
		for (int i = 0; i < 2; i++) begin
			x[i] = $urandom;
			u_host.bus_wr(SEL_ADDRESS, 8'h05 + 8'(i));
			u_host.bus_wr(SEL_DATA, x[i]);
			u_host.bus_rd(SEL_ADDRESS, d);
			check_byte(d, 8'h05 + 8'(i));
			u_host.bus_wr(SEL_ADDRESS, 8'h05 + 8'(i));
			u_host.bus_rd(SEL_DATA, d);
			check_byte(d, x[i] & reg_mask(8'h05 + 8'(i)));
		end
		check_byte(oscillator_control, x[0]);
		check_byte({load_cap_auto_stepping, 3'h0, load_cap_level},
			x[1] & 8'h8F);
		$display("test single registers done");
		c = $urandom;
		u_host.wr32(8'h00, c);
		u_host.rd32(8'h00, v);
		check_word(v, c);
		u_host.wr32(8'h08, c + 32'h3);
		u_host.bus_wr(SEL_ADDRESS, 8'h07);
		u_host.bus_wr(SEL_DATA, 8'h01);
		u_host.bus_wr(SEL_ADDRESS, 8'h04);
		u_host.bus_wr(SEL_DATA, 8'h82);
		u_host.bus_idle();
		ticks(6);
		check_count(n_wake, 1);
		u_host.bus_wr(SEL_ADDRESS, 8'h07);
		u_host.bus_rd(SEL_DATA, d);
		check_byte(d, 8'h11);
		u_host.bus_wr(SEL_ADDRESS, 8'h04);
		u_host.bus_wr(SEL_DATA, 8'h81);
		u_host.bus_idle();
		u_host.rd32(8'h00, v);
		check_word(v, c + 32'h6);
		$display("test counter and alarm done");
		u_host.bus_wr(SEL_ADDRESS, 8'h04);
		u_host.bus_wr(SEL_DATA, 8'hC0);
		u_host.bus_idle();
		repeat (4200) @(posedge core_clk);
		check_count(n_miss, 1);
		check_count(n_reset, 0);
		u_host.bus_wr(SEL_ADDRESS, 8'h04);
		u_host.bus_rd(SEL_DATA, d);
		check_byte(d, 8'hC4);
		$display("test missing clock done");
		complete_run();
	end
endmodule
